/* tb/tb.sv */
// Testbench: directed scenarios for the wake input monitor
`timescale 1ns/100ps
module tb;
   logic       clk_in = 1'b0;
   logic       rst_in = 1'b1;
   logic [2:0] lvl = 3'h0;
   logic [2:0] closed = 3'h7;
   logic [2:0] pins;
   logic [1:0] fail_output_pins_in = 2'h0;
   logic [1:0] op_mode_in = 2'h0;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic       wr_in = 1'b0;
   logic       rd_in = 1'b0;
   logic [7:0] rdata_out;
   logic       irq_out;
   logic       wake_out;
   logic       act_a, act_b;
   logic [2:0] pull_up_out;
   logic [2:0] pull_down_out;
   logic       sw, si;
   int         error_cnt = 0;
   int         n_checks = 0;
   initial forever #5 clk_in = ~clk_in;
   wim_switch_model wim_switch_model_inst (.clk_in(clk_in), .closed_in(closed), .level_in(lvl),
      .pull_up_in(pull_up_out), .pull_down_in(pull_down_out), .pin_out(pins));
   wim_top #(.SHORT_FILTER_CYCLES(4), .LONG_FILTER_CYCLES(8), .CYCLIC_TICK_CYCLES(10)) wim_top_inst (
      .*, .wake_pin_one_in(pins[0]), .wake_pin_two_in(pins[1]), .wake_pin_three_in(pins[2]),
      .cyclic_timer_a_active_out(act_a), .cyclic_timer_b_active_out(act_b));
   // ----------------
   // Shared tasks
   // ----------------
   task end_sim;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk(rdata_out, exp);
   endtask : rdc
   task pin(input int k, input logic b);
      @(posedge clk_in);
      lvl[k] <= b;
   endtask : pin
   // Span well past filter and status latency
   task wt;
      {sw, si} = 2'b00;
      repeat (40)
      begin
         @(posedge clk_in);
         #1;
         sw |= wake_out;
         si |= irq_out;
      end
   endtask : wt
   task wta(input logic val);
      for (int k = 0; k < 100 && act_a !== val; k++)
      begin
         @(posedge clk_in);
         #1;
      end
      chk(act_a, val);
   endtask : wta
   // ----------------
   // Scenarios
   // ----------------
   task t_regs;
      for (int a = 0; a < 11; a++)
         rdc(8'(a), 8'h00);
      wr(8'h00, 8'h07);
      rdc(8'h00, 8'h07);
      wr(8'h05, 8'h07);
      rdc(8'h05, 8'h00);
      rdc(8'h40, 8'h00);
   endtask : t_regs
   task t_edge;
      wr(8'h07, 8'h1F);
      op_mode_in <= 2'b01;
      repeat (2)
      begin
         pin(0, ~lvl[0]);
         wt();
         chk(si, 1'b1);
         rdc(8'h06, 8'h01);
         rdc(8'h05, {5'h00, lvl});
         wr(8'h06, 8'h01);
      end
      rdc(8'h06, 8'h00);
   endtask : t_edge
   task t_glitch;
      pin(1, 1'b1);
      pin(1, 1'b0);
      wt();
      chk(si, 1'b0);
      wr(8'h02, 8'h04);
      pin(1, 1'b1);
      repeat (5) @(posedge clk_in);
      pin(1, 1'b0);
      wt();
      chk(si, 1'b0);
      pin(1, 1'b1);
      wt();
      chk(si, 1'b1);
      rdc(8'h06, 8'h02);
      wr(8'h06, 8'h02);
      wr(8'h02, 8'h00);
   endtask : t_glitch
   task t_bias;
      @(posedge clk_in);
      closed[2] <= 1'b0;
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h01, 8'(k << 4));
         repeat (2) @(posedge clk_in);
         #1;
         chk({pull_up_out[2], pull_down_out[2]}, {k > 1, k == 1});
         repeat (20) @(posedge clk_in);
      end
      @(posedge clk_in);
      closed[2] <= 1'b1;
      wt();
      chk({pull_up_out[2], pull_down_out[2]}, 2'b01);
      wr(8'h06, 8'h1F);
   endtask : t_bias
   task t_sleep;
      wr(8'h00, 8'h01);
      for (int m = 2; m < 4; m++)
      begin
         @(posedge clk_in);
         op_mode_in <= 2'(m);
         pin(1, ~lvl[1]);
         wt();
         chk(sw, 1'b0);
         pin(0, ~lvl[0]);
         wt();
         chk({sw, si}, 2'b10);
         rdc(8'h03, 8'h01);
         wr(8'h03, 8'h01);
      end
      @(posedge clk_in);
      op_mode_in <= 2'b00;
   endtask : t_sleep
   task t_alt;
      wr(8'h08, 8'h01);
      @(posedge clk_in);
      fail_output_pins_in <= 2'b01;
      wt();
      chk(si, 1'b1);
      rdc(8'h04, 8'h01);
      rdc(8'h06, 8'h08);
      wr(8'h04, 8'h03);
      wr(8'h06, 8'h1F);
   endtask : t_alt
   task t_cyclic;
      wr(8'h09, 8'h10);
      wr(8'h02, 8'h02);
      wta(1'b1);
      wta(1'b0);
      pin(0, ~lvl[0]);
      repeat (3) @(posedge clk_in);
      rdc(8'h05, {5'h00, lvl[2:1], 1'b0});
      wta(1'b1);
      repeat (8) @(posedge clk_in);
      rdc(8'h05, {5'h00, lvl});
      rdc(8'h06, 8'h01);
      chk(act_b, 1'b1);
   endtask : t_cyclic
   initial
   begin
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      t_regs();
      t_edge();
      t_glitch();
      t_bias();
      t_sleep();
      t_alt();
      t_cyclic();
      end_sim();
   end
   // About 750 cycles needed; over ten times that
   initial
   begin
      #100000;
      error_cnt++;
      end_sim();
   end
endmodule : tb
bind wim_top wim_checker #(.SHORT_FILTER_CYCLES(SHORT_FILTER_CYCLES),
   .CYCLIC_TICK_CYCLES(CYCLIC_TICK_CYCLES)) wim_checker_inst (.*);

/* tb/wim_checker.sv */
// Checker: port-level assertions for the wake input monitor
`timescale 1ns/100ps
module wim_checker #(
   parameter int SHORT_FILTER_CYCLES = 4,
   parameter int CYCLIC_TICK_CYCLES  = 10
) (
   input wire logic       clk_in,
   input wire logic       rst_in,
   input wire logic       wake_pin_one_in,
   input wire logic       wake_pin_two_in,
   input wire logic       wake_pin_three_in,
   input wire logic [1:0] fail_output_pins_in,
   input wire logic [1:0] op_mode_in,
   input wire logic [7:0] addr_in,
   input wire logic       wr_in,
   input wire logic       rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic       irq_out,
   input wire logic       wake_out,
   input wire logic [2:0] pull_up_out,
   input wire logic [2:0] pull_down_out,
   input wire logic       cyclic_timer_a_active_out,
   input wire logic       cyclic_timer_b_active_out
);
   // ----------------
   // Cycles since any wake or fail output pin moved, and since reset
   // ----------------
   logic [15:0] quiet;
   logic [15:0] age;
   logic [4:0]  last_in;
   logic [4:0]  now_in;
   assign now_in = {fail_output_pins_in, wake_pin_three_in, wake_pin_two_in, wake_pin_one_in};
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         quiet   <= 16'h0000;
         age     <= 16'h0000;
         last_in <= 5'h00;
      end
      else
      begin
         last_in <= now_in;
         age     <= age + {15'h0000, ~&age};
         quiet   <= (now_in != last_in) ? 16'h0000 : quiet + {15'h0000, ~&quiet};
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence unmapped_read;
      rd_in && addr_in > 8'h0A;
   endsequence
   chk_bias_exclusive: assert property ((pull_up_out & pull_down_out) == 3'h0)
      else $error("pull-up and pull-down both on");
   chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside read slot");
   chk_unmapped_zero: assert property (unmapped_read |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   chk_wake_mode: assert property (wake_out |-> $past(op_mode_in[1]))
      else $error("wake pulse outside sleep or fail-safe");
   chk_wake_filtered: assert property (wake_out |-> quiet >= SHORT_FILTER_CYCLES)
      else $error("wake before filter time");
   chk_bias_cause: assert property ($changed({pull_up_out, pull_down_out}) |->
      ($past(wr_in, 2) && $past(addr_in, 2) == 8'h01) || quiet >= SHORT_FILTER_CYCLES)
      else $error("bias change without cause");
   chk_irq_cause: assert property ($rose(irq_out) |->
      quiet >= SHORT_FILTER_CYCLES || $past(wr_in) || $past(wr_in, 2))
      else $error("interrupt without cause");
   chk_timer_start: assert property (age < CYCLIC_TICK_CYCLES |->
      !cyclic_timer_a_active_out && !cyclic_timer_b_active_out)
      else $error("timer window before first tick");
endmodule : wim_checker

/* tb/wim_switch_model.sv */
// Model: external switches on the wake pins, open pins follow bias or drift
`timescale 1ns/100ps
module wim_switch_model (
   input  wire logic       clk_in,
   input  wire logic [2:0] closed_in,
   input  wire logic [2:0] level_in,
   input  wire logic [2:0] pull_up_in,
   input  wire logic [2:0] pull_down_in,
   output logic      [2:0] pin_out
);
   // Unbiased open pin toggles, so a floating input never looks steady
   logic [2:0] drift = 3'h0;
   always_ff @(posedge clk_in)
      drift <= ~drift;
   always_comb
      for (int k = 0; k < 3; k++)
         pin_out[k] = closed_in[k] ? level_in[k] : pull_up_in[k] ? 1'b1 :
                      pull_down_in[k] ? 1'b0 : drift[k];
endmodule : wim_switch_model

/* verilog/wim_cyclic_timer.sv */
// Module: cyclic sense timer giving an active window
`timescale 1ns/100ps
module wim_cyclic_timer #(
   parameter int FIELD_W = 4
) (
   input  wire logic               clk_in,
   input  wire logic               rst_in,
   input  wire logic               tick_in,
   input  wire logic [FIELD_W-1:0] period_in,
   input  wire logic [FIELD_W-1:0] on_time_in,
   output logic                    active_out
);

   typedef struct packed {
      logic [FIELD_W-1:0] cnt;
      logic               active;
   } wim_timer_state_t;

   wim_timer_state_t q;
   wim_timer_state_t next_q;

   if (FIELD_W < 1)
   begin : g_check
      $error("wim_cyclic_timer: field width must be at least one");
   end

   // Period is period_in+1 ticks, window is the first on_time_in+1 ticks of it
   always_comb
   begin
      next_q = q;
      if (tick_in)
      begin
         if (q.cnt >= period_in)
            next_q.cnt = '0;
         else
            next_q.cnt = q.cnt + FIELD_W'(1);
         next_q.active = (next_q.cnt <= on_time_in); // R05
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         q <= '0;
      else
         q <= next_q;
   end

   assign active_out = q.active;

endmodule : wim_cyclic_timer

/* verilog/wim_glitch_filter.sv */
// Module: restartable glitch filter for one wake input
`timescale 1ns/100ps
module wim_glitch_filter #(
   parameter int SHORT_CYCLES = 1600,
   parameter int LONG_CYCLES  = 6400,
   parameter int CNT_W        = 13
) (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic sense_in,
   input  wire logic enable_in,
   input  wire logic long_sel_in,
   output logic      level_out,
   output logic      event_out
);

   typedef struct packed {
      logic             last;
      logic             stable;
      logic             pend;
      logic [CNT_W-1:0] cnt;
      logic             evt;
   } wim_filter_state_t;

   wim_filter_state_t q;
   wim_filter_state_t next_q;
   logic [CNT_W-1:0]  term;

   if (SHORT_CYCLES < 1 || LONG_CYCLES < 1 || LONG_CYCLES >= 2**CNT_W
       || SHORT_CYCLES >= 2**CNT_W)
   begin : g_check
      $error("wim_glitch_filter: filter counts do not fit the counter");
   end

   assign term = long_sel_in ? CNT_W'(LONG_CYCLES - 1) : CNT_W'(SHORT_CYCLES - 1);

   always_comb
   begin
      next_q     = q;
      next_q.evt = 1'b0;
      if (!enable_in)
      begin
         // Outside the window a change seen at the next window counts as a crossing
         next_q.last = q.stable;
         next_q.pend = 1'b0;
         next_q.cnt  = '0;
      end
      else if (sense_in != q.last)
      begin
         next_q.last = sense_in; // R03
         next_q.pend = 1'b1; // R13
         next_q.cnt  = '0; // R13
      end
      else if (q.pend)
      begin
         if (q.cnt == term)
         begin
            next_q.pend = 1'b0;
            if (sense_in != q.stable)
            begin
               next_q.stable = sense_in; // R03
               next_q.evt    = 1'b1; // R01
            end
         end
         else
         begin
            next_q.cnt = q.cnt + CNT_W'(1); // R13
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         q <= '0;
      else
         q <= next_q;
   end

   assign level_out = q.stable;
   assign event_out = q.evt;

endmodule : wim_glitch_filter

/* verilog/wim_pkg.sv */
// Package: constants for the wake input monitor
package wim_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ             = 100;
   localparam int SHORT_FILTER_TIME_US = 16;
   localparam int LONG_FILTER_TIME_US  = 64;
   localparam int CYCLIC_TICK_TIME_US  = 1000;
   localparam int SHORT_FILTER_CYCLES = SHORT_FILTER_TIME_US * CLK_MHZ;
   localparam int LONG_FILTER_CYCLES  = LONG_FILTER_TIME_US * CLK_MHZ;
   localparam int CYCLIC_TICK_CYCLES  = CYCLIC_TICK_TIME_US * CLK_MHZ;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_WAKE_ENABLE_CONTROL   = 8'h00;
   localparam logic [7:0] ADDR_WAKE_BIAS_CONTROL     = 8'h01;
   localparam logic [7:0] ADDR_WAKE_FILTER_CONTROL   = 8'h02;
   localparam logic [7:0] ADDR_WAKE_EVENT_STATUS     = 8'h03;
   localparam logic [7:0] ADDR_ALT_WAKE_EVENT_STATUS = 8'h04;
   localparam logic [7:0] ADDR_WAKE_LEVEL_STATUS     = 8'h05;
   localparam logic [7:0] ADDR_IRQ_STATUS            = 8'h06;
   localparam logic [7:0] ADDR_IRQ_MASK              = 8'h07;
   localparam logic [7:0] ADDR_ALT_INPUT_CONTROL     = 8'h08;
   localparam logic [7:0] ADDR_CYCLIC_TIMER_A_CONTROL = 8'h09;
   localparam logic [7:0] ADDR_CYCLIC_TIMER_B_CONTROL = 8'h0A;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int TIMER_PERIOD_LSB = 4;
   localparam int TIMER_ON_LSB     = 0;
   localparam int IRQ_ALT_LSB      = 3;
   localparam logic [2:0] RST_WAKE_ENABLE = 3'h0;
   localparam logic [5:0] RST_BIAS        = 6'h00;
   localparam logic [5:0] RST_FILTER      = 6'h00;
   localparam logic [4:0] RST_IRQ_MASK    = 5'h00;
   localparam logic [7:0] RST_TIMER       = 8'h00;

   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      WIM_MODE_NORMAL    = 2'b00,
      WIM_MODE_STOP      = 2'b01,
      WIM_MODE_SLEEP     = 2'b10,
      WIM_MODE_FAIL_SAFE = 2'b11
   } wim_op_mode_t;

   localparam logic [1:0] BIAS_NONE      = 2'b00;
   localparam logic [1:0] BIAS_PULL_DOWN = 2'b01;
   localparam logic [1:0] BIAS_PULL_UP   = 2'b10;
   localparam logic [1:0] BIAS_AUTO      = 2'b11;

   localparam logic [1:0] FILT_STATIC_SHORT = 2'b00;
   localparam logic [1:0] FILT_STATIC_LONG  = 2'b01;
   localparam logic [1:0] FILT_CYCLIC_A     = 2'b10;
   localparam logic [1:0] FILT_CYCLIC_B     = 2'b11;

endpackage : wim_pkg

/* verilog/wim_top.sv */
// Module: wake input monitor with filters, bias control and status registers
//
// What this block does
// R01 - Each wake input signals an event on both rising and falling crossings.
// R02 - Events interrupt in normal or stop mode; they wake in sleep or fail-safe.
// R03 - Each crossing restarts the filter; a crossing before expiry discards the event.
// R04 - Filter field: 00 static 16us, 01 static 64us, 10/11 cyclic timer a/b 16us.
// R05 - Static sense evaluates always; cyclic sense only inside the timer window.
// R06 - Bias field: 00 none, 01 pull-down, 10 pull-up, 11 automatic switching.
// R07 - Automatic bias pulls up while input is high, down while it is low.
// R08 - Each pin's wake ability is enabled by its bit in wake enable control.
// R09 - Pins that caused a wake are recorded in wake event status, always readable.
// R10 - In normal and stop modes level status shows each pin's level, enabled or not.
// R11 - Under cyclic sense the level status holds levels sampled in the window.
// R12 - Fail outputs used as wake inputs get fixed static 16us filter, own status.
// R13 - Filter is a counter restarted on every crossing, valid at terminal count.
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/100ps
module wim_top #(
   parameter int SHORT_FILTER_CYCLES = wim_pkg::SHORT_FILTER_CYCLES,
   parameter int LONG_FILTER_CYCLES  = wim_pkg::LONG_FILTER_CYCLES,
   parameter int CYCLIC_TICK_CYCLES  = wim_pkg::CYCLIC_TICK_CYCLES,
   parameter int FILTER_CNT_W        = 13,
   parameter int TICK_CNT_W          = 17
) (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       wake_pin_one_in,
   input  wire logic       wake_pin_two_in,
   input  wire logic       wake_pin_three_in,
   input  wire logic [1:0] fail_output_pins_in,
   input  wire logic [1:0] op_mode_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   output logic            irq_out,
   output logic            wake_out,
   output logic      [2:0] pull_up_out,
   output logic      [2:0] pull_down_out,
   output logic            cyclic_timer_a_active_out,
   output logic            cyclic_timer_b_active_out
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (CYCLIC_TICK_CYCLES < 1 || CYCLIC_TICK_CYCLES > 2**TICK_CNT_W)
   begin : g_check_tick
      $error("wim_top: tick count does not fit the tick counter");
   end

   if (SHORT_FILTER_CYCLES > LONG_FILTER_CYCLES)
   begin : g_check_filter
      $error("wim_top: short filter must not exceed long filter");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0]            wake_enable_control;
      logic [5:0]            wake_bias_control;
      logic [5:0]            wake_filter_control;
      logic [2:0]            wake_event_status;
      logic [1:0]            alt_wake_event_status;
      logic [2:0]            wake_level_status;
      logic [4:0]            irq_status;
      logic [4:0]            irq_mask;
      logic                  alt_input_enable;
      logic [7:0]            cyclic_timer_a_control;
      logic [7:0]            cyclic_timer_b_control;
      logic [TICK_CNT_W-1:0] tick_cnt;
      logic                  tick;
      logic [7:0]            rdata;
      logic                  irq;
      logic                  wake;
      logic [2:0]            pull_up;
      logic [2:0]            pull_down;
   } wim_state_t;

   wim_state_t q;
   wim_state_t next_q;

   logic [4:0] sense;
   logic [4:0] filt_enable;
   logic [4:0] filt_long;
   logic [4:0] filt_level;
   logic [4:0] filt_event;
   logic [2:0] pin_window;
   logic       timer_a_active;
   logic       timer_b_active;

   assign sense = {fail_output_pins_in, wake_pin_three_in, wake_pin_two_in, wake_pin_one_in};

   // ------------------------------------------------------------
   // Cyclic sense timers
   // ------------------------------------------------------------
   wim_cyclic_timer #(
      .FIELD_W (4)
   ) u_cyclic_timer_a (
      .clk_in     (clk_in),
      .rst_in     (rst_in),
      .tick_in    (q.tick),
      .period_in  (q.cyclic_timer_a_control[wim_pkg::TIMER_PERIOD_LSB +: 4]),
      .on_time_in (q.cyclic_timer_a_control[wim_pkg::TIMER_ON_LSB +: 4]),
      .active_out (timer_a_active)
   );

   wim_cyclic_timer #(
      .FIELD_W (4)
   ) u_cyclic_timer_b (
      .clk_in     (clk_in),
      .rst_in     (rst_in),
      .tick_in    (q.tick),
      .period_in  (q.cyclic_timer_b_control[wim_pkg::TIMER_PERIOD_LSB +: 4]),
      .on_time_in (q.cyclic_timer_b_control[wim_pkg::TIMER_ON_LSB +: 4]),
      .active_out (timer_b_active)
   );

   assign cyclic_timer_a_active_out = timer_a_active;
   assign cyclic_timer_b_active_out = timer_b_active;

   // ------------------------------------------------------------
   // Per channel filters: three wake pins, two fail output pins
   // ------------------------------------------------------------
   for (genvar k = 0; k < 5; k++)
   begin : g_chan
      if (k < 3)
      begin : g_wake
         logic [1:0] mode;
         assign mode = q.wake_filter_control[2*k +: 2];
         assign pin_window[k] = (mode == wim_pkg::FILT_CYCLIC_A) ? timer_a_active : // R04
                                (mode == wim_pkg::FILT_CYCLIC_B) ? timer_b_active : // R04
                                1'b1; // R05
         assign filt_enable[k] = pin_window[k];
         assign filt_long[k]   = (mode == wim_pkg::FILT_STATIC_LONG); // R04
      end
      else
      begin : g_alt
         // Fail output pins only monitor while switched to their wake role
         assign filt_enable[k] = q.alt_input_enable; // R12
         assign filt_long[k]   = 1'b0; // R12
      end

      wim_glitch_filter #(
         .SHORT_CYCLES (SHORT_FILTER_CYCLES),
         .LONG_CYCLES  (LONG_FILTER_CYCLES),
         .CNT_W        (FILTER_CNT_W)
      ) u_filter (
         .clk_in      (clk_in),
         .rst_in      (rst_in),
         .sense_in    (sense[k]),
         .enable_in   (filt_enable[k]),
         .long_sel_in (filt_long[k]),
         .level_out   (filt_level[k]),
         .event_out   (filt_event[k])
      );
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic       awake;
      logic [4:0] irq_set;
      logic [4:0] irq_clr;
      logic [2:0] evt_set;
      logic [2:0] evt_clr;
      logic [1:0] alt_set;
      logic [1:0] alt_clr;
      awake   = 1'b0;
      irq_set = '0;
      irq_clr = '0;
      evt_set = '0;
      evt_clr = '0;
      alt_set = '0;
      alt_clr = '0;
      next_q  = q;

      // Shared tick for both cyclic timers
      if (q.tick_cnt == TICK_CNT_W'(CYCLIC_TICK_CYCLES - 1))
      begin
         next_q.tick_cnt = '0;
         next_q.tick     = 1'b1;
      end
      else
      begin
         next_q.tick_cnt = q.tick_cnt + TICK_CNT_W'(1);
         next_q.tick     = 1'b0;
      end

      awake = (op_mode_in == wim_pkg::WIM_MODE_NORMAL) || (op_mode_in == wim_pkg::WIM_MODE_STOP);

      // Event routing by operating mode
      if (awake)
      begin
         irq_set = filt_event; // R02
      end
      else
      begin
         evt_set = filt_event[2:0] & q.wake_enable_control; // R08
         alt_set = filt_event[4:3];
      end
      // Fail output events are reported in their own status in every mode
      alt_set = alt_set | filt_event[4:3]; // R12
      next_q.wake = !awake && ((|evt_set) || (|filt_event[4:3])); // R02

      // Register writes
      if (wr_in)
      begin
         unique case (addr_in)
            wim_pkg::ADDR_WAKE_ENABLE_CONTROL:
               next_q.wake_enable_control = wdata_in[2:0]; // R08
            wim_pkg::ADDR_WAKE_BIAS_CONTROL:
               next_q.wake_bias_control = wdata_in[5:0];
            wim_pkg::ADDR_WAKE_FILTER_CONTROL:
               next_q.wake_filter_control = wdata_in[5:0];
            wim_pkg::ADDR_WAKE_EVENT_STATUS:
               evt_clr = wdata_in[2:0];
            wim_pkg::ADDR_ALT_WAKE_EVENT_STATUS:
               alt_clr = wdata_in[1:0];
            wim_pkg::ADDR_IRQ_STATUS:
               irq_clr = wdata_in[4:0];
            wim_pkg::ADDR_IRQ_MASK:
               next_q.irq_mask = wdata_in[4:0];
            wim_pkg::ADDR_ALT_INPUT_CONTROL:
               next_q.alt_input_enable = wdata_in[0];
            wim_pkg::ADDR_CYCLIC_TIMER_A_CONTROL:
               next_q.cyclic_timer_a_control = wdata_in;
            wim_pkg::ADDR_CYCLIC_TIMER_B_CONTROL:
               next_q.cyclic_timer_b_control = wdata_in;
            default:
               ; // Unmapped writes are dropped
         endcase
      end

      // Sticky flags: a new event beats a clear in the same cycle
      next_q.wake_event_status     = (q.wake_event_status & ~evt_clr) | evt_set; // R09
      next_q.alt_wake_event_status = (q.alt_wake_event_status & ~alt_clr) | alt_set; // R12
      next_q.irq_status            = (q.irq_status & ~irq_clr) | irq_set;
      next_q.irq = |(next_q.irq_status & next_q.irq_mask);

      // Level status, frozen outside normal and stop
      if (awake)
      begin
         for (int k = 0; k < 3; k++)
         begin
            if (pin_window[k])
               next_q.wake_level_status[k] = sense[k]; // R10 R11
         end
      end

      // Bias sources
      for (int k = 0; k < 3; k++)
      begin
         unique case (q.wake_bias_control[2*k +: 2])
            wim_pkg::BIAS_NONE:
            begin
               next_q.pull_up[k]   = 1'b0; // R06
               next_q.pull_down[k] = 1'b0; // R06
            end
            wim_pkg::BIAS_PULL_DOWN:
            begin
               next_q.pull_up[k]   = 1'b0; // R06
               next_q.pull_down[k] = 1'b1; // R06
            end
            wim_pkg::BIAS_PULL_UP:
            begin
               next_q.pull_up[k]   = 1'b1; // R06
               next_q.pull_down[k] = 1'b0; // R06
            end
            wim_pkg::BIAS_AUTO:
            begin
               // Follows the filtered level so a glitch cannot flip the bias
               next_q.pull_up[k]   = filt_level[k]; // R07
               next_q.pull_down[k] = !filt_level[k]; // R07
            end
         endcase
      end

      // Read data stands for one cycle only
      next_q.rdata = 8'h00;
      if (rd_in)
      begin
         unique case (addr_in)
            wim_pkg::ADDR_WAKE_ENABLE_CONTROL:
               next_q.rdata = {5'h00, q.wake_enable_control};
            wim_pkg::ADDR_WAKE_BIAS_CONTROL:
               next_q.rdata = {2'h0, q.wake_bias_control};
            wim_pkg::ADDR_WAKE_FILTER_CONTROL:
               next_q.rdata = {2'h0, q.wake_filter_control};
            wim_pkg::ADDR_WAKE_EVENT_STATUS:
               next_q.rdata = {5'h00, q.wake_event_status}; // R09
            wim_pkg::ADDR_ALT_WAKE_EVENT_STATUS:
               next_q.rdata = {6'h00, q.alt_wake_event_status};
            wim_pkg::ADDR_WAKE_LEVEL_STATUS:
               next_q.rdata = {5'h00, q.wake_level_status}; // R10
            wim_pkg::ADDR_IRQ_STATUS:
               next_q.rdata = {3'h0, q.irq_status};
            wim_pkg::ADDR_IRQ_MASK:
               next_q.rdata = {3'h0, q.irq_mask};
            wim_pkg::ADDR_ALT_INPUT_CONTROL:
               next_q.rdata = {7'h00, q.alt_input_enable};
            wim_pkg::ADDR_CYCLIC_TIMER_A_CONTROL:
               next_q.rdata = q.cyclic_timer_a_control;
            wim_pkg::ADDR_CYCLIC_TIMER_B_CONTROL:
               next_q.rdata = q.cyclic_timer_b_control;
            default:
               next_q.rdata = 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         q                        <= '0;
         q.wake_enable_control    <= wim_pkg::RST_WAKE_ENABLE;
         q.wake_bias_control      <= wim_pkg::RST_BIAS; // R06
         q.wake_filter_control    <= wim_pkg::RST_FILTER;
         q.irq_mask               <= wim_pkg::RST_IRQ_MASK;
         q.cyclic_timer_a_control <= wim_pkg::RST_TIMER;
         q.cyclic_timer_b_control <= wim_pkg::RST_TIMER;
      end
      else
      begin
         q <= next_q;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rdata_out     = q.rdata;
   assign irq_out       = q.irq;
   assign wake_out      = q.wake;
   assign pull_up_out   = q.pull_up;
   assign pull_down_out = q.pull_down;

endmodule : wim_top
